// File: src/ssd_pkg.sv
// Constants and types for the status, identity and readback register bank
package ssd_pkg;

  // ==========================================================
  // Command codes (decoded SPI instructions)
  typedef enum logic [2:0] {
    SSD_CMD_NONE,
    SSD_CMD_READ_DEVICE_CODE,
    SSD_CMD_READ_REVISION,
    SSD_CMD_CLEAR_DIAG,
    SSD_CMD_READ_INPUTS_LOW,
    SSD_CMD_READ_INPUTS_HIGH,
    SSD_CMD_WRITE_SUPPLY_CFG,
    SSD_CMD_READ_SUPPLY_CFG
  } ssd_cmd_t;

  // ==========================================================
  // Identity values (arbitrary, neutral)
  localparam logic [7:0] SSD_DEVICE_CODE   = 8'h5A;
  localparam logic [3:0] SSD_SW_REV        = 4'h1;
  localparam logic [3:0] SSD_MASK_REV      = 4'h2;

  // ==========================================================
  // Supply status/config field positions
  localparam int SSD_BIT_OV        = 0;
  localparam int SSD_BIT_UV        = 1;
  localparam int SSD_BIT_EN_PIN    = 2;
  localparam int SSD_BIT_FAULT     = 3;
  localparam int SSD_BIT_OT        = 4;
  localparam int SSD_BIT_OV_LATCH  = 5;
  localparam int SSD_BIT_TEST_SEL  = 6;
  localparam int SSD_BIT_TEST_OFF  = 7;

  // ==========================================================
  // Reset values and sizes
  localparam logic [7:0]  SSD_DIAG_RESET  = 8'hFF;
  localparam logic [15:0] SSD_FRAME_RESET = 16'hFFFF;
  localparam int          SSD_NUM_DIAG    = 5;
  localparam int          SSD_TEST_BIT    = 8;
  localparam int          SSD_NUM_STAGES  = 18;

endpackage : ssd_pkg

// File: src/ssd_status_bank.sv
// Status, identity, input readback and diagnostic clear logic
// How it works
// - Device-code read returns eight-bit read-only identity code.
// - Revision read: software release upper nibble, mask set lower.
// - Clear command sets fault-free bits of the five fault registers and the overtemp flag to one.
// - Clear only releases bits whose fault input is absent.
// - Clear is a write with any data byte; the byte is ignored.
// - Clear restarts stages shut off by short, filter timer restarted.
// - Clear leaves current limitation; re-entered if short persists.
// - Low readback: inputs one to five in bits 0-4, bit 5 zero.
// - Low readback bit 6 is fast-bus test bit of last frame.
// - Low readback bit 7 is inverted input eight level.
// - High readback: inputs nine to fifteen in bits 0-6, bit 7 zero.
// - Readback samples live unlatched pin levels at the read.
// - Multiplex select zero disables pull-ups on inputs 1-5, 9-15.
// - Bit 0 low while overvoltage present or stored; latch disable clears.
// - Stored overvoltage survives external reset; cleared by undervoltage reset.
// - Bit 1 low while supply is in undervoltage.
// - Bit 2 shows current output-enable pin level.
// - Bit 3 low when any fault register holds a fault.
// - Bit 4 sticky overtemp, cleared by clear, reset low, undervoltage.
// - Bit 5 enables overvoltage latching, resets to one.
// - Bit 6 picks lower or upper threshold test, resets to one.
// - Bit 7 zero turns threshold test on, resets to one.
// - Multiplex select one: parallel inputs; zero: fast serial bus.
// - Fast-bus frame captured in sixteen-bit register on sync rising.
// - Supply out of range drives enable pin low, stages off.
`timescale 1ns/1ps

module ssd_status_bank (
  // Clock and resets
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               uv_reset_n_i,
  // Decoded instruction port
  input  wire ssd_pkg::ssd_cmd_t  cmd_i,
  input  wire logic               cmd_valid_i,
  input  wire logic [7:0]         cmd_wdata_i,
  output logic [7:0]              cmd_rdata_o,
  output logic                    cmd_rvalid_o,
  // Parallel input pins and multiplex
  input  wire logic [15:1]        par_in_i,
  input  wire logic               bus_multiplex_select_i,
  output logic                    pullup_en_o,
  output logic                    parallel_ctrl_en_o,
  // Fast serial bus
  input  wire logic               fast_bus_data_i,
  input  wire logic               fast_bus_clk_i,
  input  wire logic               frame_sync_input_i,
  output logic [15:0]             fast_frame_o,
  // Supply monitor
  input  wire logic               supply_ov_i,
  input  wire logic               supply_uv_i,
  output logic                    threshold_test_on_o,
  output logic                    threshold_test_select_o,
  // Output enable pin (open drain)
  input  wire logic               output_enable_pin_i,
  output logic                    output_enable_pin_o,
  output logic                    output_enable_pin_oe_o,
  output logic                    stages_off_o,
  // Channel faults
  input  wire logic [39:0]        fault_in_i,
  input  wire logic [17:0]        ot_in_i,
  input  wire logic [17:0]        scb_in_i,
  output logic [39:0]             channel_fault_regs_o,
  output logic [17:0]             scb_restart_o,
  output logic                    clear_pulse_o
);
  import ssd_pkg::*;

  // ==========================================================
  // Helpers
  // Rising edge between present and previous sample
  function automatic logic rose_now(input logic cur, input logic prev);
    return cur && !prev;
  endfunction : rose_now

  // Strobe for one decoded command
  function automatic logic cmd_hit(input ssd_cmd_t want,
                                   input ssd_cmd_t got,
                                   input logic     valid);
    return valid && (got == want);
  endfunction : cmd_hit

  // ==========================================================
  // Pin synchronisers: three stages, change accepted when 2,3 agree
  localparam int NS = 20;
  logic [NS-1:0] s1_q, s2_q, s3_q, pin_q;
  logic [NS-1:0] raw;
  assign raw = {output_enable_pin_i, fast_bus_data_i, fast_bus_clk_i,
                frame_sync_input_i, supply_uv_i, par_in_i};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NS; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic [15:1] pin_in;
  logic        sync_l, fclk_l, fdat_l, ov_l, uv_l, en_pin_l;
  assign pin_in   = pin_q[14:0];
  assign uv_l     = pin_q[15];
  assign sync_l   = pin_q[16];
  assign fclk_l   = pin_q[17];
  assign fdat_l   = pin_q[18];
  assign en_pin_l = pin_q[19];

  // ==========================================================
  // Overvoltage synchroniser, cleared only by undervoltage reset
  // Keeps detecting while external reset is low
  logic ov_s1_q, ov_s2_q, ov_s3_q, ov_pin_q;
  always_ff @(posedge clk_i or negedge uv_reset_n_i) begin
    if (!uv_reset_n_i) begin
      ov_s1_q  <= 1'b0;
      ov_s2_q  <= 1'b0;
      ov_s3_q  <= 1'b0;
      ov_pin_q <= 1'b0;
    end else begin
      ov_s1_q <= supply_ov_i;
      ov_s2_q <= ov_s1_q;
      ov_s3_q <= ov_s2_q;
      if (ov_s2_q == ov_s3_q) begin
        ov_pin_q <= ov_s3_q;
      end
    end
  end
  assign ov_l = ov_pin_q;

  // ==========================================================
  // Fast serial bus receiver
  logic        fclk_d1_q, sync_d1_q;
  logic [15:0] shift_q, frame_q;
  // Previous samples for edge detection; both idle low
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fclk_d1_q <= 1'b0;
      sync_d1_q <= 1'b0;
    end else begin
      fclk_d1_q <= fclk_l;
      sync_d1_q <= sync_l;
    end
  end

  // First bit sent ends in bit 0 after sixteen clocks
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_q <= SSD_FRAME_RESET;
    end else if (rose_now(fclk_l, fclk_d1_q)) begin
      shift_q <= {fdat_l, shift_q[15:1]};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_q <= SSD_FRAME_RESET;
    end else if (rose_now(sync_l, sync_d1_q)) begin
      frame_q <= shift_q;
    end
  end
  assign fast_frame_o = frame_q;

  assign parallel_ctrl_en_o = bus_multiplex_select_i;
  assign pullup_en_o        = bus_multiplex_select_i;

  // ==========================================================
  // Command strobes
  logic clr;
  logic wr_cfg;
  assign clr    = cmd_hit(SSD_CMD_CLEAR_DIAG, cmd_i, cmd_valid_i);
  assign wr_cfg = cmd_hit(SSD_CMD_WRITE_SUPPLY_CFG, cmd_i, cmd_valid_i);
  assign clear_pulse_o = clr;

  // ==========================================================
  // Configuration bits 7..5
  logic ov_latch_en_q, test_sel_q, test_off_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ov_latch_en_q <= 1'b1;
    end else if (wr_cfg) begin
      ov_latch_en_q <= cmd_wdata_i[SSD_BIT_OV_LATCH];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      test_sel_q <= 1'b1;
    end else if (wr_cfg) begin
      test_sel_q <= cmd_wdata_i[SSD_BIT_TEST_SEL];
    end
  end

  // only bits 7..5 writable, status bits have no store
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      test_off_q <= 1'b1;
    end else if (wr_cfg) begin
      test_off_q <= cmd_wdata_i[SSD_BIT_TEST_OFF];
    end
  end
  assign threshold_test_on_o     = !test_off_q;
  // selection only acts in test mode
  assign threshold_test_select_o = !test_off_q && test_sel_q;

  // ==========================================================
  // Stored overvoltage: not cleared by external reset
  logic ov_stored_q;
  // only undervoltage reset or latch disable erases
  always_ff @(posedge clk_i or negedge uv_reset_n_i) begin
    if (!uv_reset_n_i) begin
      ov_stored_q <= 1'b0;
    end else if (ov_l && ov_latch_en_q) begin
      ov_stored_q <= 1'b1;
    end else if (!ov_latch_en_q) begin
      ov_stored_q <= 1'b0;
    end
  end

  logic ov_seen, supply_bad;
  assign ov_seen    = ov_l || ov_stored_q;
  assign supply_bad = ov_seen || uv_l;
  // pull enable pin low, stages off
  // Open drain: the pin is only ever pulled low, never driven high
  assign output_enable_pin_o    = 1'b0;
  assign output_enable_pin_oe_o = supply_bad;
  assign stages_off_o           = supply_bad || !en_pin_l;

  // ==========================================================
  // Channel fault registers (2 bits per stage, 11 = ok)
  logic [39:0] diag_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      diag_q <= {SSD_NUM_DIAG{SSD_DIAG_RESET}};
    end else if (uv_l) begin
      diag_q <= {SSD_NUM_DIAG{SSD_DIAG_RESET}};
    end else begin
      for (int i = 0; i < 40; i++) begin
        // fault at input wins over clear
        if (!fault_in_i[i]) begin
          diag_q[i] <= 1'b0;
        end else if (clr) begin
          diag_q[i] <= 1'b1;
        end
      end
    end
  end
  assign channel_fault_regs_o = diag_q;

  // current limitation left, re-entered if short stays
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scb_restart_o <= '0;
    end else begin
      scb_restart_o <= clr ? scb_in_i : '0;
    end
  end

  // ==========================================================
  // Common overtemperature flag
  logic ot_flag_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ot_flag_q <= 1'b1;
    end else if (|ot_in_i) begin
      ot_flag_q <= 1'b0;
    end else if (uv_l) begin
      ot_flag_q <= 1'b1;
    // released only if no fault present
    end else if (clr) begin
      ot_flag_q <= 1'b1;
    end
  end

  // ==========================================================
  // Status/config assembly
  logic [7:0] stat;
  always_comb begin
    stat = '0;
    stat[SSD_BIT_OV]       = !ov_seen;
    stat[SSD_BIT_UV]       = !uv_l;
    stat[SSD_BIT_EN_PIN]   = en_pin_l;
    stat[SSD_BIT_FAULT]    = &diag_q;
    stat[SSD_BIT_OT]       = ot_flag_q;
    stat[SSD_BIT_OV_LATCH] = ov_latch_en_q;
    stat[SSD_BIT_TEST_SEL] = test_sel_q;
    stat[SSD_BIT_TEST_OFF] = test_off_q;
  end

  // ==========================================================
  // Input readback bytes from live synchronised levels
  logic [7:0] inp_low, inp_high;
  always_comb begin
    inp_low      = '0;
    // inputs one to five, bit 5 stays zero
    inp_low[4:0] = pin_in[5:1];
    inp_low[5]   = 1'b0;
    // test bit from last latched frame
    inp_low[6]   = frame_q[SSD_TEST_BIT];
    inp_low[7]   = !pin_in[8];
  end

  // inputs nine to fifteen, bit 7 zero
  always_comb begin
    inp_high      = '0;
    inp_high[6:0] = pin_in[15:9];
    inp_high[7]   = 1'b0;
  end

  // ==========================================================
  // Read data
  logic [7:0] rd_d;
  always_comb begin
    case (cmd_i)
      SSD_CMD_READ_DEVICE_CODE: rd_d = SSD_DEVICE_CODE;
      SSD_CMD_READ_REVISION:    rd_d = {SSD_SW_REV, SSD_MASK_REV};
      SSD_CMD_READ_INPUTS_LOW:  rd_d = inp_low;
      SSD_CMD_READ_INPUTS_HIGH: rd_d = inp_high;
      SSD_CMD_READ_SUPPLY_CFG:  rd_d = stat;
      default:                  rd_d = 8'h00;
    endcase
  end

  // Answer strobe, one cycle after the command
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_rvalid_o <= 1'b0;
    end else begin
      cmd_rvalid_o <= cmd_valid_i;
    end
  end

  // Read byte holds until the next command
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_rdata_o <= 8'h00;
    end else if (cmd_valid_i) begin
      cmd_rdata_o <= rd_d;
    end
  end

endmodule : ssd_status_bank

// File: sim/ssd_status_sva.sv
// Port-level assertions for the status bank
`timescale 1ns/1ps

module ssd_status_sva
  import ssd_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              reset_n_i,
  input wire ssd_pkg::ssd_cmd_t cmd_i,
  input wire logic              cmd_valid_i,
  input wire logic [7:0]        cmd_rdata_o,
  input wire logic              cmd_rvalid_o,
  input wire logic              supply_uv_i,
  input wire logic [39:0]       fault_in_i,
  input wire logic [17:0]       scb_in_i,
  input wire logic [39:0]       channel_fault_regs_o,
  input wire logic [17:0]       scb_restart_o,
  input wire logic              clear_pulse_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_req(ssd_cmd_t c);
    cmd_valid_i && cmd_i == c;
  endsequence

  // ==========================================================
  // Read answers
  a_device_code: assert property (
    s_req(SSD_CMD_READ_DEVICE_CODE) |=> cmd_rvalid_o &&
      cmd_rdata_o == SSD_DEVICE_CODE) else $error("bad device code");
  a_revision_code: assert property (
    s_req(SSD_CMD_READ_REVISION) |=>
      cmd_rdata_o == {SSD_SW_REV, SSD_MASK_REV}) else $error("bad revision");
  a_low_spare_zero: assert property (
    s_req(SSD_CMD_READ_INPUTS_LOW) |=> !cmd_rdata_o[5])
    else $error("low readback bit 5 set");
  a_high_spare_zero: assert property (
    s_req(SSD_CMD_READ_INPUTS_HIGH) |=> !cmd_rdata_o[7])
    else $error("high readback bit 7 set");
  a_fault_summary: assert property (
    s_req(SSD_CMD_READ_SUPPLY_CFG) |=>
      cmd_rdata_o[3] == &$past(channel_fault_regs_o))
    else $error("common fault flag wrong");
  a_uv_flag_high: assert property (
    !supply_uv_i [*6] ##0 s_req(SSD_CMD_READ_SUPPLY_CFG) |=> cmd_rdata_o[1])
    else $error("undervoltage flag low without undervoltage");

  // ==========================================================
  // Clear command
  a_clear_sets: assert property (
    s_req(SSD_CMD_CLEAR_DIAG) ##0 fault_in_i == '1 |=>
      channel_fault_regs_o == '1) else $error("clear left a fault bit");
  a_clear_keeps: assert property (
    s_req(SSD_CMD_CLEAR_DIAG) |=>
      (channel_fault_regs_o & ~$past(fault_in_i)) == '0)
    else $error("clear dropped a present fault");
  a_clear_strobe: assert property (
    s_req(SSD_CMD_CLEAR_DIAG) |-> clear_pulse_o) else $error("no clear strobe");
  a_scb_restart: assert property (
    s_req(SSD_CMD_CLEAR_DIAG) |=> scb_restart_o == $past(scb_in_i))
    else $error("restart pulse wrong");
endmodule : ssd_status_sva

bind ssd_status_bank ssd_status_sva ssd_status_sva_i (
  .clk_i, .reset_n_i, .cmd_i, .cmd_valid_i, .cmd_rdata_o, .cmd_rvalid_o,
  .supply_uv_i, .fault_in_i, .scb_in_i, .channel_fault_regs_o,
  .scb_restart_o, .clear_pulse_o
);

// File: sim/ssd_fast_bus_model.sv
// Fast serial bus sender driving the frame pins
`timescale 1ns/1ps

module ssd_fast_bus_model (
  // Clock
  input  wire logic clk_i,
  // Bus pins
  output logic      fast_bus_data_o,
  output logic      fast_bus_clk_o,
  output logic      frame_sync_o
);
  initial {fast_bus_data_o, fast_bus_clk_o, frame_sync_o} = 3'b000;

  // Bit 0 first; bus clock still outside frames
  task automatic send_frame(input logic [15:0] word);
    for (int i = 0; i < 16; i++) begin
      fast_bus_data_o = word[i];
      repeat (4) @(posedge clk_i);
      #1 fast_bus_clk_o = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 fast_bus_clk_o = 1'b0;
    end
    fast_bus_data_o = ~fast_bus_data_o;
    frame_sync_o = 1'b1;
    repeat (6) @(posedge clk_i);
    #1 frame_sync_o = 1'b0;
  endtask : send_frame
endmodule : ssd_fast_bus_model

// File: sim/tb_top.sv
// Self-checking bench for the status bank
`timescale 1ns/1ps

module tb_top;
  import ssd_pkg::*;
  logic clk_i, reset_n_i, uv_reset_n_i, cmd_valid_i, cmd_rvalid_o;
  logic bus_multiplex_select_i, pullup_en_o, parallel_ctrl_en_o;
  logic fast_bus_data_i, fast_bus_clk_i, frame_sync_input_i;
  logic supply_ov_i, supply_uv_i, threshold_test_on_o;
  logic threshold_test_select_o, output_enable_pin_o;
  logic output_enable_pin_oe_o, stages_off_o, clear_pulse_o;
  ssd_cmd_t    cmd_i;
  logic [7:0]  cmd_wdata_i, cmd_rdata_o;
  logic [15:1] par_in_i;
  logic [15:0] fast_frame_o;
  logic [39:0] fault_in_i, channel_fault_regs_o;
  logic [17:0] ot_in_i, scb_in_i, scb_restart_o;
  wire logic   output_enable_pin_i;
  int          fails, total_checks;

  // Open-drain pin with pull-up
  assign output_enable_pin_i = output_enable_pin_oe_o ?
                               output_enable_pin_o : 1'b1;

  ssd_status_bank ssd_status_bank_i (
    .clk_i, .reset_n_i, .uv_reset_n_i, .cmd_i, .cmd_valid_i, .cmd_wdata_i,
    .cmd_rdata_o, .cmd_rvalid_o, .par_in_i, .bus_multiplex_select_i,
    .pullup_en_o, .parallel_ctrl_en_o, .fast_bus_data_i, .fast_bus_clk_i,
    .frame_sync_input_i, .fast_frame_o, .supply_ov_i, .supply_uv_i,
    .threshold_test_on_o, .threshold_test_select_o, .output_enable_pin_i,
    .output_enable_pin_o, .output_enable_pin_oe_o, .stages_off_o,
    .fault_in_i, .ot_in_i, .scb_in_i, .channel_fault_regs_o,
    .scb_restart_o, .clear_pulse_o);

  ssd_fast_bus_model ssd_fast_bus_model_i (.clk_i,
    .fast_bus_data_o(fast_bus_data_i), .fast_bus_clk_o(fast_bus_clk_i),
    .frame_sync_o(frame_sync_input_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Tasks
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt

  task automatic cmp(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic op(input ssd_cmd_t c, input logic [7:0] d, e, m);
    cmd_i = c;
    cmd_wdata_i = d;
    cmd_valid_i = 1'b1;
    wt(1);
    cmp({7'h00, cmd_rvalid_o}, 8'h01);
    cmp(cmd_rdata_o & m, e);
    if (c == SSD_CMD_CLEAR_DIAG) cmp(scb_restart_o[7:0], scb_in_i[7:0]);
    cmd_valid_i = 1'b0;
    wt(1);
  endtask : op

  task automatic rd_cfg(input logic [7:0] e, m);
    op(SSD_CMD_READ_SUPPLY_CFG, 8'h00, e, m);
  endtask : rd_cfg

  task automatic ov_pulse;
    supply_ov_i = 1'b1;
    wt(10);
    cmp({7'h00, output_enable_pin_oe_o}, 8'h01);
    cmp({6'h00, output_enable_pin_o, stages_off_o}, 8'h01);
    rd_cfg(8'h00, 8'h05);
    supply_ov_i = 1'b0;
    wt(6);
  endtask : ov_pulse

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    #100000;
    fails++;
    give_verdict();
  end

  // ==========================================================
  // Tests
  initial begin
    {reset_n_i, uv_reset_n_i, cmd_valid_i, supply_ov_i, supply_uv_i} = '0;
    cmd_i = SSD_CMD_NONE;
    {cmd_wdata_i, par_in_i, ot_in_i, scb_in_i} = '0;
    {fails, total_checks} = '0;
    bus_multiplex_select_i = 1'b1;
    fault_in_i = '1;
    wt(3);
    {reset_n_i, uv_reset_n_i} = 2'b11;
    wt(6);
    op(SSD_CMD_READ_DEVICE_CODE, 8'h00, SSD_DEVICE_CODE, 8'hFF);
    op(SSD_CMD_READ_REVISION, 8'h00, {SSD_SW_REV, SSD_MASK_REV}, 8'hFF);
    $display("test identity done");
    for (int i = 0; i < 2; i++) begin
      par_in_i = i[0] ? 15'h2A55 : 15'h55AA;
      bus_multiplex_select_i = i[0];
      wt(6);
      cmp({6'h00, pullup_en_o, parallel_ctrl_en_o}, {6'h00, {2{i[0]}}});
      op(SSD_CMD_READ_INPUTS_LOW, 8'h00,
         {~par_in_i[8], 2'b10, par_in_i[5:1]}, 8'hFF);
      op(SSD_CMD_READ_INPUTS_HIGH, 8'h00, {1'b0, par_in_i[15:9]}, 8'hFF);
    end
    ssd_fast_bus_model_i.send_frame(16'hA0B5);
    wt(8);
    cmp(fast_frame_o[7:0], 8'hB5);
    cmp(fast_frame_o[15:8], 8'hA0);
    op(SSD_CMD_READ_INPUTS_LOW, 8'h00, 8'h00, 8'h60);
    $display("test readback done");
    rd_cfg(8'hFF, 8'hFF);
    op(SSD_CMD_WRITE_SUPPLY_CFG, 8'h40, 8'h00, 8'h00);
    cmp({6'h00, threshold_test_on_o, threshold_test_select_o}, 8'h03);
    rd_cfg(8'h5F, 8'hFF);
    op(SSD_CMD_WRITE_SUPPLY_CFG, 8'h80, 8'h00, 8'h00);
    cmp({6'h00, threshold_test_on_o, threshold_test_select_o}, 8'h00);
    op(SSD_CMD_WRITE_SUPPLY_CFG, 8'hE0, 8'h00, 8'h00);
    $display("test config done");
    ov_pulse();
    rd_cfg(8'h00, 8'h01);
    reset_n_i = 1'b0;
    wt(2);
    reset_n_i = 1'b1;
    wt(6);
    rd_cfg(8'h00, 8'h01);
    uv_reset_n_i = 1'b0;
    wt(2);
    uv_reset_n_i = 1'b1;
    wt(6);
    rd_cfg(8'h01, 8'h01);
    reset_n_i = 1'b0;
    supply_ov_i = 1'b1;
    wt(8);
    supply_ov_i = 1'b0;
    wt(6);
    reset_n_i = 1'b1;
    wt(6);
    rd_cfg(8'h00, 8'h01);
    ov_pulse();
    op(SSD_CMD_WRITE_SUPPLY_CFG, 8'hC0, 8'h00, 8'h00);
    rd_cfg(8'h01, 8'h21);
    op(SSD_CMD_WRITE_SUPPLY_CFG, 8'hE0, 8'h00, 8'h00);
    supply_uv_i = 1'b1;
    wt(6);
    rd_cfg(8'h00, 8'h02);
    supply_uv_i = 1'b0;
    wt(6);
    $display("test supply done");
    fault_in_i[3] = 1'b0;
    ot_in_i[0] = 1'b1;
    wt(6);
    rd_cfg(8'h00, 8'h18);
    ot_in_i[0] = 1'b0;
    scb_in_i[2] = 1'b1;
    wt(6);
    op(SSD_CMD_CLEAR_DIAG, 8'h3C, 8'h00, 8'h00);
    rd_cfg(8'h10, 8'h18);
    fault_in_i[3] = 1'b1;
    scb_in_i[2] = 1'b0;
    wt(6);
    op(SSD_CMD_CLEAR_DIAG, 8'hC3, 8'h00, 8'h00);
    rd_cfg(8'h18, 8'h18);
    cmp(channel_fault_regs_o[39:32] & channel_fault_regs_o[7:0], 8'hFF);
    $display("test clear done");
    give_verdict();
  end
endmodule : tb_top
